// file: rtl/ppcw_defs.vh
// Constants for the profile position control word interpreter
`ifndef PPCW_DEFS_VH
`define PPCW_DEFS_VH

`define PPCW_ADDR_CTRL 16'h6040
`define PPCW_ADDR_STAT 16'h6041
`define PPCW_ADDR_TGT 16'h607A
`define PPCW_ADDR_WRAPMODE 16'h414F
`define PPCW_ADDR_HALTOPT 16'h605D
`define PPCW_ADDR_CMDPOS 16'h6062
`define PPCW_ADDR_ACTPOS 16'h6064
`define PPCW_ADDR_FLAGS 16'h4100

`define PPCW_BIT_WRAP 14
`define PPCW_BIT_PUSH 13
`define PPCW_BIT_REF 12
`define PPCW_BIT_HALT 8
`define PPCW_BIT_REL 6
`define PPCW_BIT_IMM 5
`define PPCW_BIT_START 4
`define PPCW_MASK_USED 16'h717F

`define PPCW_STAT_ACK 12
`define PPCW_STAT_DONE 10

`define PPCW_CTRL_RESET 16'h0000
`define PPCW_ZERO32 32'h00000000
`define PPCW_ZERO16 16'h0000

`define PPCW_CUR_RUN 2'h0
`define PPCW_CUR_PUSH 2'h1
`define PPCW_CUR_STOP 2'h2

`endif

// file: rtl/ppcw_edge_sync.v
// Three-stage synchroniser with agreement-based change detection
`timescale 1ns/1ps
`default_nettype none
module ppcw_edge_sync (
    input wire ref_clk,
    input wire rst,
    input wire din,
    output reg level
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/ppcw_target_calc.v
// Destination calculator for absolute and incremental moves
`timescale 1ns/1ps
`default_nettype none
`include "ppcw_defs.vh"
module ppcw_target_calc #(
    parameter W = 32
) (
    input wire [W-1:0] targetValue,
    input wire [W-1:0] commandPos,
    input wire [W-1:0] actualPos,
    input wire relative,
    input wire refActual,
    output reg [W-1:0] destination
);
    always @* begin
        if (!relative) begin
            destination = targetValue;
        end else if (refActual) begin
            destination = actualPos + targetValue;
        end else begin
            destination = commandPos + targetValue;
        end
    end
endmodule
`default_nettype wire

// file: rtl/ppcw_control_word.v
// Profile position control word interpreter top level
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ppcw_defs.vh"
module ppcw_control_word #(
    parameter W = 32
) (
    input wire ref_clk,
    input wire rst,
    input wire [15:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWrite,
    input wire regRead,
    output reg [31:0] regRdata,
    input wire stopInput,
    input wire operationEnabled,
    input wire motorExcited,
    input wire moveDone,
    input wire [W-1:0] actualPos,
    output reg moveStart,
    output reg [W-1:0] moveDest,
    output reg moveWrap,
    output reg [1:0] wrapMode,
    output reg movePush,
    output reg haltRequest,
    output reg [15:0] haltOption,
    output reg [1:0] currentSelect,
    output reg setpointAck,
    output reg moveActive
);
    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_MOVE = 3'b010;
    localparam ST_STOP = 3'b100;

    reg [15:0] ctrlWord;
    reg [15:0] prevCtrl;
    reg [W-1:0] targetReg;
    reg [W-1:0] commandPos;
    reg [2:0] state;
    reg [2:0] next_state;
    reg pendValid;
    reg [W-1:0] pendDest;
    reg pendWrap;
    reg pendPush;
    reg stopSync;
    wire [W-1:0] calcDest;
    wire startEdge;
    wire startOk;
    wire pushStop;

    ppcw_edge_sync u_stop (
        .ref_clk(ref_clk),
        .rst(rst),
        .din(stopInput),
        .level(stopSync)
    );

    ppcw_target_calc #(.W(W)) u_calc (
        .targetValue(targetReg),
        .commandPos(commandPos),
        .actualPos(actualPos),
        .relative(ctrlWord[`PPCW_BIT_REL]),
        .refActual(ctrlWord[`PPCW_BIT_REF]),
        .destination(calcDest)
    );

    // ------------------------------------------------------------
    // Start qualification
    // ------------------------------------------------------------
    assign startEdge = ctrlWord[`PPCW_BIT_START] & ~prevCtrl[`PPCW_BIT_START];
    assign startOk = startEdge & ~ctrlWord[`PPCW_BIT_HALT] & ~stopSync
        & operationEnabled & motorExcited;
    assign pushStop = movePush & (ctrlWord[`PPCW_BIT_HALT] | stopSync);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrlWord <= `PPCW_CTRL_RESET;
            targetReg <= `PPCW_ZERO32;
            wrapMode <= 2'h0;
            haltOption <= `PPCW_ZERO16;
            regRdata <= 32'h00000000;
        end else begin
            if (regWrite) begin
                case (regAddr)
                    `PPCW_ADDR_CTRL: begin
                        ctrlWord <= regWdata[15:0] & `PPCW_MASK_USED;
                    end
                    `PPCW_ADDR_TGT: begin
                        targetReg <= regWdata[W-1:0];
                    end
                    `PPCW_ADDR_WRAPMODE: begin
                        wrapMode <= regWdata[1:0];
                    end
                    `PPCW_ADDR_HALTOPT: begin
                        haltOption <= regWdata[15:0];
                    end
                    default: begin
                    end
                endcase
            end
            regRdata <= 32'h00000000;
            if (regRead) begin
                case (regAddr)
                    `PPCW_ADDR_CTRL: regRdata <= {16'h0000, ctrlWord};
                    `PPCW_ADDR_STAT: regRdata <= {19'h0, setpointAck, 1'b0,
                        state == ST_IDLE, 10'h0};
                    `PPCW_ADDR_TGT: regRdata <= targetReg;
                    `PPCW_ADDR_WRAPMODE: regRdata <= {30'h0, wrapMode};
                    `PPCW_ADDR_HALTOPT: regRdata <= {16'h0000, haltOption};
                    `PPCW_ADDR_CMDPOS: regRdata <= commandPos;
                    `PPCW_ADDR_ACTPOS: regRdata <= actualPos;
                    `PPCW_ADDR_FLAGS: regRdata <= {27'h0, pendValid, currentSelect,
                        movePush, moveWrap};
                    default: regRdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Move sequencer
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (startOk) begin
                    next_state = ST_MOVE;
                end
            end
            ST_MOVE: begin
                if (pushStop) begin
                    next_state = ST_STOP;
                end else if (moveDone && !pendValid) begin
                    next_state = ST_STOP;
                end
            end
            ST_STOP: begin
                if (startOk) begin
                    next_state = ST_MOVE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prevCtrl <= `PPCW_CTRL_RESET;
            state <= ST_IDLE;
            commandPos <= `PPCW_ZERO32;
            pendValid <= 1'b0;
            pendDest <= `PPCW_ZERO32;
            pendWrap <= 1'b0;
            pendPush <= 1'b0;
            moveStart <= 1'b0;
            moveDest <= `PPCW_ZERO32;
            moveWrap <= 1'b0;
            movePush <= 1'b0;
            haltRequest <= 1'b0;
            currentSelect <= `PPCW_CUR_RUN;
            setpointAck <= 1'b0;
            moveActive <= 1'b0;
        end else begin
            prevCtrl <= ctrlWord;
            state <= next_state;
            moveStart <= 1'b0;
            haltRequest <= ctrlWord[`PPCW_BIT_HALT];
            moveActive <= (next_state == ST_MOVE);
            if (startOk) begin
                setpointAck <= 1'b1;
            end else if (!ctrlWord[`PPCW_BIT_START]) begin
                setpointAck <= 1'b0;
            end
            if (startOk && state == ST_MOVE && !ctrlWord[`PPCW_BIT_IMM]) begin
                pendValid <= 1'b1;
                pendDest <= calcDest;
                pendWrap <= ctrlWord[`PPCW_BIT_WRAP];
                pendPush <= ctrlWord[`PPCW_BIT_PUSH];
            end else if (startOk) begin
                pendValid <= 1'b0;
                moveStart <= 1'b1;
                moveDest <= calcDest;
                commandPos <= calcDest;
                moveWrap <= ctrlWord[`PPCW_BIT_WRAP];
                movePush <= ctrlWord[`PPCW_BIT_PUSH];
                currentSelect <= ctrlWord[`PPCW_BIT_PUSH] ? `PPCW_CUR_PUSH
                    : `PPCW_CUR_RUN;
            end else if (state == ST_MOVE && moveDone && pendValid && !pushStop) begin
                pendValid <= 1'b0;
                moveStart <= 1'b1;
                moveDest <= pendDest;
                commandPos <= pendDest;
                moveWrap <= pendWrap;
                movePush <= pendPush;
                currentSelect <= pendPush ? `PPCW_CUR_PUSH : `PPCW_CUR_RUN;
            end else if (state == ST_MOVE && next_state == ST_STOP) begin
                pendValid <= 1'b0;
                if (movePush) begin
                    currentSelect <= `PPCW_CUR_STOP;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/ppcw_asserts.sv
// Checker for the control word interpreter ports
`timescale 1ns/1ps
`default_nettype none
module ppcw_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [15:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic operationEnabled,
    input wire logic motorExcited,
    input wire logic moveStart,
    input wire logic moveActive,
    input wire logic moveWrap,
    input wire logic movePush,
    input wire logic haltRequest,
    input wire logic [1:0] currentSelect,
    input wire logic setpointAck
);
    wire logic cw = regWrite && regAddr == 16'h6040;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_start_pulse: assert property (moveStart |=> !moveStart)
        else $error("start pulse too long");
    a_start_edge: assert property ($rose(moveActive)
        |-> $past(cw, 2) && $past(regWdata[4], 2))
        else $error("move without start edge");
    a_halt_refuse: assert property (cw && regWdata[8] |-> ##2 !moveStart)
        else $error("start taken under halt");
    a_ack_gated: assert property ($rose(setpointAck)
        |-> $past(operationEnabled) && $past(motorExcited))
        else $error("ack while not ready");
    a_ack_clear: assert property (cw && !regWdata[4] |-> ##2 !setpointAck)
        else $error("ack not cleared");
    a_ack_start: assert property ($rose(moveActive) |-> setpointAck)
        else $error("move without ack");
    a_halt_mirror: assert property (cw |-> ##2 haltRequest == $past(regWdata[8], 2))
        else $error("halt request wrong");
    a_mode_bits: assert property ($rose(moveActive) |-> moveWrap == $past(regWdata[14], 2)
        && movePush == $past(regWdata[13], 2))
        else $error("mode bits wrong");
    a_push_current: assert property ($rose(moveActive) && movePush
        |-> ##[0:1] currentSelect == 2'h1)
        else $error("no push current");
    a_stop_current: assert property (cw && regWdata[8] && movePush && moveActive
        |-> ##[1:4] currentSelect == 2'h2)
        else $error("no stop current");
endmodule
bind ppcw_control_word ppcw_asserts chk (.*);
`default_nettype wire

// file: tb/ppcw_master_model.sv
// Fieldbus master model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module ppcw_master_model (
    input wire logic ref_clk,
    output logic [15:0] regAddr,
    output logic [31:0] regWdata,
    output logic regWrite,
    output logic regRead,
    input wire logic [31:0] regRdata
);
    initial begin
        regAddr = 16'h0000;
        regWdata = 32'h00000000;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    task wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask
    task rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRdata;
    endtask
endmodule
`default_nettype wire

// file: tb/profile_position_control_word_bench.sv
// Self-checking bench for the control word interpreter
`timescale 1ns/1ps
`default_nettype none
module profile_position_control_word_bench;
    logic ref_clk, rst, regWrite, regRead, stopInput, operationEnabled, motorExcited, moveDone;
    logic moveStart, moveWrap, movePush, haltRequest, setpointAck, moveActive, got;
    logic [15:0] regAddr, haltOption;
    logic [31:0] regWdata, regRdata, actualPos, moveDest, rd;
    logic [1:0] wrapMode, currentSelect;
    int errors, n_checks, cyc;
    ppcw_control_word uut (.*);
    ppcw_master_model m (.*);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            give_verdict();
        end
    end
    task chk(input logic ok, input string s);
        n_checks++;
        if (!ok) begin
            errors++;
            $display("[FAIL] %0t %s", $time, s);
        end
    endtask
    task give_verdict();
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task go(input logic [15:0] cw);
        m.wr(16'h6040, {16'h0000, cw & 16'hFFEF});
        repeat (3) @(posedge ref_clk);
        m.wr(16'h6040, {16'h0000, cw});
        @(posedge ref_clk);
        #1;
    endtask
    task finish_move();
        @(posedge ref_clk);
        moveDone <= 1'b1;
        @(posedge ref_clk);
        moveDone <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task t_abs();
        m.wr(16'h607A, 32'h00000064);
        go(16'h0010);
        chk(moveStart === 1'b1 && moveDest === 32'h00000064, "absolute move");
        m.rd(16'h6041, rd);
        chk(rd[12] === 1'b1, "ack status");
        m.wr(16'h6040, 32'h00000010);
        @(posedge ref_clk);
        #1;
        chk(moveStart === 1'b0, "level restarted");
        finish_move();
        m.wr(16'h6040, 32'h00000000);
        @(posedge ref_clk);
        #1;
        chk(setpointAck === 1'b0, "ack kept");
    endtask
    task t_rel();
        m.wr(16'h607A, 32'h00000032);
        go(16'h0050);
        chk(moveDest === 32'h00000096, "command based");
        finish_move();
        actualPos <= 32'h000003E8;
        go(16'h1050);
        chk(moveDest === 32'h0000041A, "actual based");
        finish_move();
    endtask
    task t_refuse();
        for (int i = 0; i < 4; i++) begin
            stopInput <= i == 1;
            operationEnabled <= i != 2;
            motorExcited <= i != 3;
            repeat (5) @(posedge ref_clk);
            go(i == 0 ? 16'h0110 : 16'h0010);
            chk(moveStart === 1'b0 && setpointAck === 1'b0, "start taken");
            @(posedge ref_clk);
        end
        stopInput <= 1'b0;
        operationEnabled <= 1'b1;
        motorExcited <= 1'b1;
        repeat (5) @(posedge ref_clk);
    endtask
    task t_queue();
        go(16'h0010);
        go(16'h0010);
        chk(moveStart === 1'b0, "queued start ran early");
        got = 1'b0;
        @(posedge ref_clk);
        moveDone <= 1'b1;
        @(posedge ref_clk);
        moveDone <= 1'b0;
        #1;
        got = moveStart;
        repeat (3) begin
            @(posedge ref_clk);
            #1;
            got |= moveStart;
        end
        chk(got === 1'b1 && moveActive === 1'b1, "queued start lost");
        go(16'h0030);
        chk(moveStart === 1'b1, "immediate change");
        finish_move();
    endtask
    task t_push_wrap();
        m.wr(16'h605D, 32'h00000002);
        go(16'h2010);
        chk(movePush === 1'b1 && currentSelect === 2'h1, "push");
        m.wr(16'h6040, 32'h00002110);
        repeat (4) @(posedge ref_clk);
        #1;
        chk(haltRequest === 1'b1 && haltOption === 16'h0002, "halt");
        chk(currentSelect === 2'h2, "stop current");
        m.wr(16'h414F, 32'h00000003);
        go(16'h4610);
        chk(moveStart === 1'b1 && moveWrap === 1'b1 && wrapMode === 2'h3, "wrap");
        m.rd(16'h6040, rd);
        chk(rd[15:0] === 16'h4010, "masked bits");
        finish_move();
    endtask
    initial begin
        rst = 1'b1;
        stopInput = 1'b0;
        operationEnabled = 1'b1;
        motorExcited = 1'b1;
        moveDone = 1'b0;
        actualPos = 32'h00000000;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_abs();
        t_rel();
        t_refuse();
        t_queue();
        t_push_wrap();
        give_verdict();
    end
endmodule
`default_nettype wire
